// >>> rtl/ebi_ctrl.v
// External bus controller: arbitration, cycle timing and pin control
`timescale 1ns/1ps
`include "ebi_defines.vh"
module ebi_ctrl (
    input  wire        core_clk_in,               // Core clock, 25 MHz
    input  wire        rstn_in,                   // Async reset, active low
    input  wire        cpu_clock_in,              // CPU clock from outside
    input  wire [1:0]  proc_mode_in,              // 0 single, 1 exp, 2 micro
    input  wire [3:0]  width_per_space_in,        // 1 = 16-bit space
    input  wire        width_load_in,             // Load space 3 width bit
    input  wire        byte_width_strap_in,       // High = space 3 8-bit
    input  wire [1:0]  chip_select_layout_in,     // Selects minus one
    input  wire        strobe_combo_select_in,    // 1 = byte store strobes
    input  wire        internal_mem_wait_in,      // Extra internal clock
    input  wire        sfr_wait_in,               // Extra register clock
    input  wire [19:0] wait_cycle_code_in,        // Five bits per space
    input  wire [3:0]  recovery_cycle_enable_in,  // Per space
    input  wire [1:0]  bus_mux_select_in,         // Multiplexed spaces
    input  wire [1:0]  ale_pin_select_in,         // Latch strobe pin
    input  wire        bus_clock_output_disable_in, // 1 = no clock out
    input  wire [1:0]  clock_output_select_in,    // Clock pin function
    input  wire        cpu_req_in,                // CPU access request
    input  wire [1:0]  cpu_kind_in,               // Internal, SFR, external
    input  wire [1:0]  cpu_space_in,              // External space index
    input  wire [23:0] cpu_addr_in,               // CPU address
    input  wire        cpu_write_in,              // CPU write
    input  wire        cpu_word_in,               // CPU word access
    input  wire [15:0] cpu_wdata_in,              // CPU write data
    output reg         cpu_done_out,              // CPU access done
    input  wire        dma_req_in,                // DMA access request
    input  wire [1:0]  dma_kind_in,               // Internal, SFR, external
    input  wire [1:0]  dma_space_in,              // External space index
    input  wire [23:0] dma_addr_in,               // DMA address
    input  wire        dma_write_in,              // DMA write
    input  wire        dma_word_in,               // DMA word access
    input  wire [15:0] dma_wdata_in,              // DMA write data
    output reg         dma_done_out,              // DMA access done
    output reg  [15:0] rdata_out,                 // Read data
    output wire [23:0] addr_pin_out,              // Address and select pins
    output wire [23:0] addr_pin_oe_out,           // Per-line enable
    input  wire [15:0] addr_pin_in,               // Muxed lines read back
    output wire [15:0] data_pin_out,              // Data bus
    output wire [15:0] data_pin_oe_out,           // Per-line enable
    input  wire [15:0] data_pin_in,               // Data bus read back
    output reg         read_strobe_n_out,         // Read strobe
    output reg         low_byte_store_n_out,      // Low or single store
    output reg         high_byte_store_n_out,     // High byte store
    output reg         upper_byte_enable_n_out,   // Upper byte enable
    output wire        ctrl_oe_out,               // Strobe pin enable
    input  wire        wait_request_n_in,         // Wait request pin
    input  wire        bus_request_n_in,          // Hold request pin
    output reg         bus_grant_n_out,           // Grant pin
    output reg         addr_latch_strobe_out,     // Dedicated latch pin
    output reg         bus_cycle_clock_out,       // Clock pin
    output wire        hold_active_out            // Bus handed over
);
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ACC  = 5'h02;
    localparam [4:0] ST_REC  = 5'h04;
    localparam [4:0] ST_HOLD = 5'h08;
    localparam [4:0] ST_INIT = 5'h10;

    wire [`EBI_SYNC_W-1:0] sync_w;
    wire [15:0] ad_s;
    wire [15:0] data_s;
    wire        lclk_s;
    wire        wait_n_s;
    wire        breq_n_s;
    wire        strap_s;
    reg         lclk_d_reg;
    reg  [4:0]  state_reg;
    reg  [1:0]  init_reg;
    reg         w3_reg;
    reg  [3:0]  cnt_reg;
    reg         first_reg;
    reg         stretch_reg;
    reg         dma_own_reg;
    reg         ext_reg;
    reg         wr_reg;
    reg         mux_reg;
    reg         w16_reg;
    reg         rec_reg;
    reg  [23:0] addr_reg;
    reg  [15:0] wdata_reg;
    reg  [3:0]  cs_n_reg;
    reg         ale_reg;
    reg         grant_n_reg;
    wire        rise;
    wire        fall;
    wire        bus_mode;
    wire        in_hold;
    wire [3:0]  width_w;
    wire        sel_dma;
    wire [1:0]  sel_kind;
    wire [1:0]  sel_space;
    wire [23:0] sel_addr;
    wire        sel_write;
    wire        sel_word;
    wire [15:0] sel_wdata;
    wire        sel_mux;
    wire [3:0]  ext_len;
    wire [2:0]  ncs;
    wire        mux_data;
    wire        ext_write_drive;
    wire        combo_bytes;
    wire [15:0] lane_oe;

    function is_mux;
        input [1:0] msel;
        input [1:0] space;
        begin
            case (msel)
                `EBI_MUX_SPACE1: is_mux = (space == 2'h1);
                `EBI_MUX_SPACE2: is_mux = (space == 2'h2);
                `EBI_MUX_ALL:    is_mux = 1'b1;
                default:         is_mux = 1'b0;
            endcase
        end
    endfunction

    ebi_sync #(.W(`EBI_SYNC_W)) u_sync (
        .clk_in  (core_clk_in),
        .rstn_in (rstn_in),
        .d_in    ({byte_width_strap_in, bus_request_n_in, wait_request_n_in,
                   cpu_clock_in, data_pin_in, addr_pin_in}),
        .q_out   (sync_w)
    );
    assign ad_s     = sync_w[15:0];
    assign data_s   = sync_w[31:16];
    assign lclk_s   = sync_w[32];
    assign wait_n_s = sync_w[33];
    assign breq_n_s = sync_w[34];
    assign strap_s  = sync_w[35];

    assign rise = lclk_s & ~lclk_d_reg;
    assign fall = ~lclk_s & lclk_d_reg;

    assign bus_mode = (proc_mode_in != `EBI_MODE_SINGLE);
    assign in_hold  = (state_reg == ST_HOLD);
    assign hold_active_out = in_hold;
    assign width_w  = {w3_reg, width_per_space_in[2:0]};

    assign sel_dma   = dma_req_in;
    assign sel_kind  = sel_dma ? dma_kind_in  : cpu_kind_in;
    assign sel_space = sel_dma ? dma_space_in : cpu_space_in;
    assign sel_addr  = sel_dma ? dma_addr_in  : cpu_addr_in;
    assign sel_write = sel_dma ? dma_write_in : cpu_write_in;
    assign sel_word  = sel_dma ? dma_word_in  : cpu_word_in;
    assign sel_wdata = sel_dma ? dma_wdata_in : cpu_wdata_in;
    assign sel_mux   = is_mux(bus_mux_select_in, sel_space);

    ebi_cycle_len u_len (
        .code_in (wait_cycle_code_in[sel_space*5 +: 5]),
        .mux_in  (sel_mux),
        .len_out (ext_len)
    );

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lclk_d_reg   <= 1'b0;
            state_reg    <= ST_INIT;
            init_reg     <= 2'h0;
            w3_reg       <= 1'b0;
            cnt_reg      <= 4'h0;
            first_reg    <= 1'b0;
            stretch_reg  <= 1'b0;
            dma_own_reg  <= 1'b0;
            ext_reg      <= 1'b0;
            wr_reg       <= 1'b0;
            mux_reg      <= 1'b0;
            w16_reg      <= 1'b0;
            rec_reg      <= 1'b0;
            addr_reg     <= 24'h000000;
            wdata_reg    <= 16'h0000;
            cs_n_reg     <= 4'hf;
            ale_reg      <= 1'b0;
            grant_n_reg  <= 1'b1;
            rdata_out    <= 16'h0000;
            cpu_done_out <= 1'b0;
            dma_done_out <= 1'b0;
            upper_byte_enable_n_out <= 1'b1;
            read_strobe_n_out       <= 1'b1;
            low_byte_store_n_out    <= 1'b1;
            high_byte_store_n_out   <= 1'b1;
        end else begin
            lclk_d_reg   <= lclk_s;
            cpu_done_out <= 1'b0;
            dma_done_out <= 1'b0;
            if (width_load_in)
                w3_reg <= width_per_space_in[3];
            case (state_reg)
                ST_INIT: begin
                    init_reg <= init_reg + 2'h1;
                    if (init_reg == `EBI_INIT_CNT) begin
                        w3_reg    <= ~strap_s;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (rise) begin
                        if (!breq_n_s) begin
                            state_reg   <= ST_HOLD;
                            grant_n_reg <= 1'b0;
                        end else if (dma_req_in || cpu_req_in) begin
                            state_reg   <= ST_ACC;
                            dma_own_reg <= sel_dma;
                            first_reg   <= 1'b1;
                            stretch_reg <= 1'b0;
                            ale_reg     <= 1'b1;
                            wr_reg      <= sel_write;
                            ext_reg     <= (sel_kind == `EBI_KIND_EXT);
                            mux_reg     <= sel_mux;
                            w16_reg     <= width_w[sel_space];
                            rec_reg     <= recovery_cycle_enable_in[sel_space];
                            wdata_reg   <= sel_wdata;
                            if (sel_kind == `EBI_KIND_EXT) begin
                                cnt_reg  <= ext_len;
                                addr_reg <= sel_addr;
                                cs_n_reg <= ~(4'h1 << sel_space);
                                if (width_w[sel_space])
                                    upper_byte_enable_n_out <=
                                        ~(sel_word | sel_addr[0]);
                                else
                                    upper_byte_enable_n_out <= 1'b1;
                            end else begin
                                cs_n_reg <= 4'hf;
                                if (sel_kind == `EBI_KIND_SFR)
                                    cnt_reg <= `EBI_LEN_SFR
                                             + {3'h0, sfr_wait_in};
                                else
                                    cnt_reg <= `EBI_LEN_ROMRAM
                                             + {3'h0, internal_mem_wait_in};
                            end
                        end
                    end
                end
                ST_ACC: begin
                    if (fall) begin
                        ale_reg <= 1'b0;
                        if (cnt_reg == 4'h1 && ext_reg)
                            stretch_reg <= ~wait_n_s;
                    end
                    if (rise) begin
                        if (cnt_reg == 4'h1 && !stretch_reg) begin
                            read_strobe_n_out     <= 1'b1;
                            low_byte_store_n_out  <= 1'b1;
                            high_byte_store_n_out <= 1'b1;
                            first_reg             <= 1'b0;
                            rdata_out   <= mux_reg ? ad_s : data_s;
                            cpu_done_out <= ~dma_own_reg;
                            dma_done_out <= dma_own_reg;
                            if (ext_reg && rec_reg && !mux_reg)
                                state_reg <= ST_REC;
                            else
                                state_reg <= ST_IDLE;
                        end else if (cnt_reg != 4'h1) begin
                            cnt_reg   <= cnt_reg - 4'h1;
                            first_reg <= 1'b0;
                            if (first_reg && ext_reg) begin
                                read_strobe_n_out <= wr_reg;
                                if (combo_bytes) begin
                                    low_byte_store_n_out  <= ~wr_reg |
                                        addr_reg[0];
                                    high_byte_store_n_out <= ~wr_reg |
                                        ~(addr_reg[0] | ~upper_byte_enable_n_out);
                                end else begin
                                    low_byte_store_n_out  <= ~wr_reg;
                                end
                            end
                        end
                    end
                end
                ST_REC: begin
                    if (rise)
                        state_reg <= ST_IDLE;
                end
                ST_HOLD: begin
                    if (breq_n_s) begin
                        grant_n_reg <= 1'b1;
                        state_reg   <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Byte store strobes only on a 16-bit space with the option set
    assign combo_bytes = strobe_combo_select_in & w16_reg;

    assign ncs = {1'b0, chip_select_layout_in} + 3'h1;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_hipin
            localparam [1:0] CSI = 2'd3 - gi;
            if (gi == 3) begin : g_top
                assign addr_pin_out[`EBI_CS_PIN_LO+gi] =
                    ({1'b0, CSI} < ncs) ? cs_n_reg[CSI] : ~addr_reg[23];
            end else begin : g_mid
                assign addr_pin_out[`EBI_CS_PIN_LO+gi] =
                    ({1'b0, CSI} < ncs) ? cs_n_reg[CSI]
                                        : addr_reg[`EBI_CS_PIN_LO+gi];
            end
        end
    endgenerate

    // Low address lines carry write data after the address phase
    assign mux_data = (state_reg == ST_ACC) & ext_reg & mux_reg & ~first_reg;
    assign lane_oe  = w16_reg ? 16'hffff : 16'h00ff;
    assign addr_pin_out[19:16] = addr_reg[19:16];
    assign addr_pin_out[15:0]  = mux_data
        ? ((wdata_reg & lane_oe) | (addr_reg[15:0] & ~lane_oe))
        : addr_reg[15:0];
    assign addr_pin_oe_out = (bus_mode && !in_hold)
        ? {8'hff, (mux_data && !wr_reg) ? ~lane_oe : 16'hffff}
        : 24'h000000;

    assign ext_write_drive = ext_reg & wr_reg & ~mux_reg &
        ((state_reg == ST_ACC) | (state_reg == ST_REC));
    assign data_pin_out    = wdata_reg;
    assign data_pin_oe_out = (bus_mode && ext_write_drive)
        ? lane_oe : 16'h0000;
    assign ctrl_oe_out     = bus_mode & ~in_hold;

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            addr_latch_strobe_out <= 1'b0;
            bus_cycle_clock_out   <= 1'b0;
            bus_grant_n_out       <= 1'b1;
        end else begin
            addr_latch_strobe_out <= bus_mode & ale_reg & ~in_hold &
                (ale_pin_select_in == `EBI_ALE_ON_PIN);
            if (bus_mode && ale_pin_select_in == `EBI_ALE_ON_CLK)
                bus_cycle_clock_out <= ale_reg & ~in_hold;
            else
                bus_cycle_clock_out <= bus_mode &
                    ~bus_clock_output_disable_in &
                    (clock_output_select_in == `EBI_CLKSEL_BUS) & lclk_s;
            if (bus_mode && ale_pin_select_in == `EBI_ALE_ON_GRANT)
                bus_grant_n_out <= ale_reg & ~in_hold;
            else
                bus_grant_n_out <= grant_n_reg | ~bus_mode;
        end
    end
endmodule

// >>> rtl/ebi_cycle_len.v
// Wait code to external bus cycle length decoder
`timescale 1ns/1ps
`include "ebi_defines.vh"
module ebi_cycle_len (
    input  wire [`EBI_CODE_W-1:0] code_in,  // Wait cycle code
    input  wire                   mux_in,   // Multiplexed bus cycle
    output reg  [`EBI_LEN_W-1:0]  len_out   // Bus clocks in the cycle
);
    always @* begin
        len_out = `EBI_LEN_DEFAULT;
        if (!mux_in) begin
            case (code_in)
                5'h01:   len_out = 4'h2;
                5'h02:   len_out = 4'h3;
                5'h03:   len_out = 4'h4;
                5'h04:   len_out = 4'h5;
                5'h05:   len_out = 4'h6;
                5'h06:   len_out = 4'h7;
                5'h0a:   len_out = 4'h4;
                5'h0b:   len_out = 4'h5;
                5'h0c:   len_out = 4'h6;
                5'h13:   len_out = 4'h6;
                5'h14:   len_out = 4'h7;
                5'h16:   len_out = 4'h9;
                default: len_out = `EBI_LEN_DEFAULT;
            endcase
        end else begin
            case (code_in)
                5'h0a:   len_out = 4'h4;
                5'h0b:   len_out = 4'h5;
                5'h0d:   len_out = 4'h7;
                5'h13:   len_out = 4'h6;
                5'h14:   len_out = 4'h7;
                5'h15:   len_out = 4'h8;
                5'h16:   len_out = 4'h9;
                default: len_out = `EBI_LEN_DEFAULT;
            endcase
        end
    end
endmodule

// >>> rtl/ebi_defines.vh
// Constants shared by the external bus controller files
`ifndef EBI_DEFINES_VH
`define EBI_DEFINES_VH

`define EBI_MODE_SINGLE   2'h0
`define EBI_KIND_ROMRAM   2'h0
`define EBI_KIND_SFR      2'h1
`define EBI_KIND_EXT      2'h2
`define EBI_MUX_NONE      2'h0
`define EBI_MUX_SPACE1    2'h1
`define EBI_MUX_SPACE2    2'h2
`define EBI_MUX_ALL       2'h3
`define EBI_ALE_ON_CLK    2'h1
`define EBI_ALE_ON_GRANT  2'h2
`define EBI_ALE_ON_PIN    2'h3
`define EBI_CLKSEL_BUS    2'h0
`define EBI_CODE_W        5
`define EBI_LEN_W         4
`define EBI_LEN_ROMRAM    4'h1
`define EBI_LEN_SFR       4'h2
`define EBI_LEN_DEFAULT   4'h9
`define EBI_CS_PIN_LO     20
`define EBI_SYNC_W        36
`define EBI_INIT_CNT      2'h3

`endif

// >>> rtl/ebi_sync.v
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module ebi_sync #(
    parameter W = 1
) (
    input  wire         clk_in,   // Core clock
    input  wire         rstn_in,  // Async reset, active low
    input  wire [W-1:0] d_in,     // Asynchronous inputs
    output wire [W-1:0] q_out     // Synchronised inputs
);
    reg [W-1:0] meta_reg;
    reg [W-1:0] sync_reg;

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_reg <= {W{1'b1}};
            sync_reg <= {W{1'b1}};
        end else begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;
endmodule

// >>> verif/ebi_ctrl_asserts.sv
// Port checker for the external bus controller
`timescale 1ns/1ps
module ebi_ctrl_asserts (
    input wire logic        core_clk_in,            // Core clock
    input wire logic        rstn_in,                // Reset
    input wire logic [1:0]  proc_mode_in,           // Mode
    input wire logic [1:0]  ale_pin_select_in,      // Latch pin
    input wire logic        bus_request_n_in,       // Hold request
    input wire logic        cpu_req_in,             // CPU request
    input wire logic [1:0]  cpu_kind_in,            // CPU kind
    input wire logic        dma_req_in,             // DMA request
    input wire logic [23:0] addr_pin_oe_out,        // Address enables
    input wire logic [15:0] data_pin_oe_out,        // Data enables
    input wire logic        ctrl_oe_out,            // Strobe enable
    input wire logic        read_strobe_n_out,      // Read strobe
    input wire logic        low_byte_store_n_out,   // Low store
    input wire logic        high_byte_store_n_out,  // High store
    input wire logic        bus_grant_n_out,        // Grant
    input wire logic        addr_latch_strobe_out,  // Latch strobe
    input wire logic        bus_cycle_clock_out,    // Clock pin
    input wire logic        hold_active_out,        // Hold state
    input wire logic        strobe_combo_select_in, // Byte strobes
    input wire logic        upper_byte_enable_n_out, // Upper enable
    input wire logic [23:0] addr_pin_out,           // Address pins
    input wire logic        cpu_done_out,           // CPU done
    input wire logic        dma_done_out            // DMA done
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    wire grant_pin = ale_pin_select_in != 2'h2;
    sequence s_hold_on;
        $rose(hold_active_out) && grant_pin;
    endsequence
    a_single_quiet: assert property ((proc_mode_in == 2'h0)[*3] |->
        addr_pin_oe_out == 24'h0 && !ctrl_oe_out) else $error("bus driven");
    a_clock_off: assert property ((proc_mode_in == 2'h0)[*3] |->
        !bus_cycle_clock_out) else $error("clock out in single-chip");
    a_hold_float: assert property (hold_active_out |-> !ctrl_oe_out &&
        addr_pin_oe_out == 24'h0 && data_pin_oe_out == 16'h0 &&
        !addr_latch_strobe_out) else $error("bus not floated in hold");
    a_hold_entry: assert property (s_hold_on |-> ##[0:1] !bus_grant_n_out)
        else $error("grant late");
    a_grant_only_hold: assert property (!bus_grant_n_out && grant_pin |->
        hold_active_out || $past(hold_active_out)) else $error("stray grant");
    a_release_grant: assert property ($rose(bus_request_n_in) && grant_pin
        |-> ##[1:6] bus_grant_n_out) else $error("grant held");
    a_strobe_excl: assert property (!read_strobe_n_out |->
        low_byte_store_n_out && high_byte_store_n_out) else $error("rd and wr");
    a_odd_no_low: assert property (strobe_combo_select_in &&
        !upper_byte_enable_n_out && addr_pin_out[0] && data_pin_oe_out[0]
        |-> low_byte_store_n_out) else $error("low strobe on odd byte");
    a_one_owner: assert property (!(cpu_done_out && dma_done_out))
        else $error("two owners");
    a_internal_quiet: assert property (cpu_req_in && cpu_kind_in != 2'h2 &&
        !dma_req_in |-> read_strobe_n_out && low_byte_store_n_out &&
        data_pin_oe_out == 16'h0) else $error("internal access on pins");
endmodule
bind ebi_ctrl ebi_ctrl_asserts u_chk (.*);

// >>> verif/ebi_ctrl_test.sv
// Self-checking bench for the external bus controller
`timescale 1ns/1ps
module ebi_ctrl_test;
    logic core_clk_in = 0, rstn_in = 0, cpu_clock_in = 0;
    logic [1:0] proc_mode_in = 2'h2, chip_select_layout_in = 2'h3;
    logic [1:0] bus_mux_select_in = 2'h0, ale_pin_select_in = 2'h3;
    logic [1:0] clock_output_select_in = 2'h0, cpu_kind_in = 2'h0;
    logic [1:0] cpu_space_in = 2'h0, dma_kind_in = 2'h2, dma_space_in = 2'h0;
    logic [3:0] width_per_space_in = 4'hf, recovery_cycle_enable_in = 4'h0;
    logic width_load_in = 0, byte_width_strap_in = 0, sfr_wait_in = 0;
    logic strobe_combo_select_in = 0, internal_mem_wait_in = 0;
    logic bus_clock_output_disable_in = 0, cpu_req_in = 0, dma_req_in = 0;
    logic cpu_write_in = 0, cpu_word_in = 1, dma_write_in = 0, dma_word_in = 1;
    logic wait_request_n_in = 1, bus_request_n_in = 1;
    logic [19:0] wait_cycle_code_in = {4{5'h01}};
    logic [23:0] cpu_addr_in = 0, dma_addr_in = 24'h000012, pins;
    logic [15:0] cpu_wdata_in = 0, dma_wdata_in = 0;
    logic cpu_done_out, dma_done_out, read_strobe_n_out, low_byte_store_n_out;
    logic high_byte_store_n_out, upper_byte_enable_n_out, ctrl_oe_out;
    logic bus_grant_n_out, addr_latch_strobe_out, bus_cycle_clock_out;
    logic hold_active_out;
    logic [15:0] rdata_out, data_pin_out, data_pin_oe_out, data_pin_in;
    logic [15:0] addr_pin_in;
    logic [23:0] addr_pin_out, addr_pin_oe_out;
    logic [8:0] tbl [19] = '{9'h012, 9'h023, 9'h034, 9'h045, 9'h056, 9'h067,
        9'h0a4, 9'h0b5, 9'h0c6, 9'h136, 9'h147, 9'h169, 9'h0a4, 9'h0b5,
        9'h0d7, 9'h136, 9'h147, 9'h158, 9'h169};
    int mismatches = 0, compares = 0, cyc, n;
    always #20 core_clk_in = ~core_clk_in;
    initial begin
        #7;
        forever #160 cpu_clock_in = ~cpu_clock_in;
    end
    ebi_ctrl u_dut (.*);
    ebi_ext_mem u_mem (.rd_n_in(read_strobe_n_out), .wrl_n_in(low_byte_store_n_out),
        .wrh_n_in(high_byte_store_n_out), .ube_n_in(upper_byte_enable_n_out),
        .addr_in(addr_pin_out), .wdata_in(data_pin_out), .rdata_out(data_pin_in));
    assign addr_pin_in = data_pin_in;
    task chk(input string what, input logic [23:0] exp, got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task print_verdict;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task tick(input int k);
        repeat (k) @(posedge core_clk_in);
        #1;
    endtask
    // One CPU access; cyc counts core clocks from latch strobe to done
    task acc(input [1:0] k, sp, input [23:0] a, input w, input [15:0] wd);
        {cpu_kind_in, cpu_space_in, cpu_addr_in} = {k, sp, a};
        {cpu_write_in, cpu_wdata_in, cpu_req_in} = {w, wd, 1'b1};
        n = 0;
        cyc = 0;
        while (!addr_latch_strobe_out && n < 2000) begin tick(1); n++; end
        while (!cpu_done_out && n < 2000) begin tick(1); n++; cyc++; end
        if (n >= 2000) mismatches++;
        pins = addr_pin_out;
        cpu_req_in = 0;
        tick(1);
    endtask
    initial begin
        tick(3);
        rstn_in = 1;
        tick(12);
        for (int i = 0; i < 4; i++) begin
            {internal_mem_wait_in, sfr_wait_in} = {2{i[0]}};
            acc(i[1], 0, 0, 0, 0);
            chk("internal len", (1+i[1]+i[0])*8-1, cyc);
        end
        for (int i = 0; i < 19; i++) begin
            bus_mux_select_in = (i > 11) ? 2'h1 : 2'h0;
            wait_cycle_code_in = {4{tbl[i][8:4]}};
            acc(2, 1, 24'h000010, 0, 0);
            chk("external len", tbl[i][3:0] * 8 - 1, cyc);
        end
        {bus_mux_select_in, wait_cycle_code_in} = {2'h0, {4{5'h01}}};
        recovery_cycle_enable_in = 4'h8;
        for (int i = 0; i < 2; i++) begin
            strobe_combo_select_in = i[0];
            acc(2, 3, 24'h000040, 1, 16'h5a3c ^ i[15:0]);
            acc(2, 3, 24'h000040, 0, 0);
            chk("read back", 16'h5a3c ^ i[15:0], rdata_out);
            chk("address", 24'he00040, pins);
            acc(2, 3, 24'h000041, 1, 16'h0000);
            chk("recovery", 16'hffff, data_pin_oe_out);
            acc(2, 3, 24'h000040, 0, 0);
            chk("byte lane", 16'h003c ^ i[15:0], rdata_out);
        end
        for (int s = 0; s < 4; s++) begin
            acc(2, s, 24'h000100 + s * 2, 0, 0);
            chk("select", 4'hf ^ (4'h8 >> s), pins[23:20]);
            acc(0, 0, 0, 0, 0);
            chk("internal pins", 24'hf00100 + s * 2, pins);
        end
        wait_request_n_in = 0;
        fork
            acc(2, 0, 24'h000010, 0, 0);
            begin tick(60); wait_request_n_in = 1; end
        join
        chk("wait stretch", 1, cyc > 16 && cyc % 8 == 7 && cyc < 100);
        bus_request_n_in = 0;
        tick(20);
        chk("hold grant", 2'b10, {hold_active_out, bus_grant_n_out});
        {cpu_kind_in, cpu_req_in, dma_req_in} = {2'h2, 2'b11};
        n = 0;
        repeat (40) begin tick(1); n += cpu_done_out | dma_done_out; end
        chk("held", 0, n);
        bus_request_n_in = 1;
        n = 0;
        while (!(cpu_done_out | dma_done_out) && n < 500) begin tick(1); n++; end
        chk("dma first", 2'b01, {cpu_done_out, dma_done_out});
        dma_req_in = 0;
        while (!cpu_done_out && n < 500) begin tick(1); n++; end
        cpu_req_in = 0;
        chk("cpu resumed", 1, cpu_done_out);
        n = 0;
        repeat (16) begin tick(1); n += bus_cycle_clock_out; end
        chk("bus clock", 8, n);
        proc_mode_in = 2'h0;
        tick(4);
        n = 0;
        repeat (24) begin tick(1); n += bus_cycle_clock_out | ctrl_oe_out; end
        chk("single chip quiet", 0, n);
        print_verdict;
    end
    initial begin
        #2000000;
        mismatches++;
        print_verdict;
    end
endmodule

// >>> verif/ebi_ext_mem.sv
// Behavioural memory on the separate external bus
`timescale 1ns/1ps
module ebi_ext_mem (
    input  wire logic        rd_n_in,   // Read strobe
    input  wire logic        wrl_n_in,  // Low or single store strobe
    input  wire logic        wrh_n_in,  // High byte store strobe
    input  wire logic        ube_n_in,  // Upper byte enable
    input  wire logic [23:0] addr_in,   // Address pins
    input  wire logic [15:0] wdata_in,  // Write data pins
    output logic      [15:0] rdata_out  // Read data pins
);
    logic [15:0] mem [0:255];
    logic [15:0] last_reg = 16'h0000;
    always @(posedge wrl_n_in) begin
        if (!addr_in[0]) mem[addr_in[8:1]][7:0] <= wdata_in[7:0];
        if (!ube_n_in) mem[addr_in[8:1]][15:8] <= wdata_in[15:8];
    end
    always @(posedge wrh_n_in) mem[addr_in[8:1]][15:8] <= wdata_in[15:8];
    always @(posedge rd_n_in) last_reg <= rdata_out;
    // Released bus shows a changed pattern, never the stale word
    assign rdata_out = rd_n_in ? ~last_reg : mem[addr_in[8:1]];
endmodule
